// ### inc/mep_pkg.sv
/*
 * mep_pkg: constants, register map and carrier types for the memory
 * error protection block.
 * Assumes a single 20 MHz system clock with a synchronous reset.
 */
package mep_pkg;

    localparam int DW       = 32;
    localparam int CW       = 39;
    localparam int L2_AW    = 14;
    localparam int NBANK    = 4;
    localparam int BANK_LSB = 12;
    localparam int REG_AW   = 4;
    localparam int NSTAT    = 6;

    // register word offsets
    localparam logic [REG_AW-1:0] REG_CTRL    = 4'h0;
    localparam logic [REG_AW-1:0] REG_STAT    = 4'h1;
    localparam logic [REG_AW-1:0] REG_MASK    = 4'h2;
    localparam logic [REG_AW-1:0] REG_CRC0RES = 4'h3;
    localparam logic [REG_AW-1:0] REG_CRC1RES = 4'h4;
    localparam logic [REG_AW-1:0] REG_CRC0EXP = 4'h5;
    localparam logic [REG_AW-1:0] REG_CRC1EXP = 4'h6;

    // control fields
    localparam int CTRL_ECC_EN_LSB = 0;
    localparam int CTRL_DED_REP    = 4;
    localparam int CTRL_CRC0_CMP   = 8;
    localparam int CTRL_CRC1_CMP   = 9;
    localparam logic [DW-1:0] CTRL_RST = 32'h0000000F;
    localparam logic [DW-1:0] MASK_RST = 32'h00000000;
    localparam logic [DW-1:0] EXP_RST  = 32'h00000000;

    // status fields
    localparam int ST_L1I  = 0;
    localparam int ST_L1D  = 1;
    localparam int ST_SEC  = 2;
    localparam int ST_DED  = 3;
    localparam int ST_CRC0 = 4;
    localparam int ST_CRC1 = 5;

    localparam logic [DW-1:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [DW-1:0] CRC_SEED = 32'hFFFFFFFF;
    localparam logic [3:0]    BE_FULL  = 4'hF;

    typedef struct packed {
        logic             valid;
        logic             we;
        logic [3:0]       be;
        logic [L2_AW-1:0] addr;
        logic [DW-1:0]    wdata;
    } mep_l2_req_t;

    typedef struct packed {
        logic          start;
        logic          valid;
        logic          last;
        logic [DW-1:0] data;
    } mep_crc_in_t;

    typedef struct packed {
        logic          wr;
        logic [DW-1:0] wdata;
        logic          rd_valid;
        logic [DW-1:0] rdata;
        logic [3:0]    rpar;
    } mep_l1_acc_t;

    typedef struct packed {
        logic [DW-1:0] data;
        logic          sgl;
        logic          dbl;
    } mep_dec_t;

endpackage : mep_pkg

// ### rtl/mep_top.sv
/*
 * mep_top: memory error protection. Byte parity for both L1 spaces,
 * SEC-DED coding with read-modify-write for L2, two DMA CRC units,
 * a small register file and one interrupt.
 * Assumes: L2 array returns read data one cycle after its read strobe,
 * inputs are synchronous to sys_clk_in.
 */
// Overview of operation
// RULE_01: several parity bits per L1 word, checked
// RULE_02: parity covers L1 instruction and data spaces
// RULE_03: L2 SEC-DED: encode on write, syndrome on read
// RULE_04: ECC on after reset, per-bank disable bits
// RULE_05: single-bit errors corrected silently, no stall
// RULE_06: double-bit error event only when reporting enabled
// RULE_07: byte/halfword writes merged to keep check bits
// RULE_08: two CRC units on two DMA streams
// RULE_09: CRC accumulates or compares during transfer
// RULE_10: repeated scrub passes over descriptor chain
// RULE_11: boot data can be routed through CRC
// RULE_12: L1 parity mismatch sets status, raises event
// RULE_13: CRC compare mismatch sets status, raises event

module mep_l1_par (
    input  wire logic                sys_clk_in,
    input  wire logic                rst_in,
    input  wire mep_pkg::mep_l1_acc_t acc_in,
    output logic [3:0]               wpar_out,
    output logic                     err_out
);
    function automatic logic [3:0] par4(input logic [31:0] d);
        logic [3:0] p;
        for (int b = 0; b < 4; b++) begin
            p[b] = ^d[8*b +: 8];
        end
        return p;
    endfunction

    // one bit per byte: byte writes never need the other bytes
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wpar_out <= 4'h0;
        end else if (acc_in.wr) begin
            wpar_out <= par4(acc_in.wdata); // [RULE_01]
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            err_out <= 1'b0;
        end else begin
            err_out <= acc_in.rd_valid &&
                       (par4(acc_in.rdata) != acc_in.rpar); // [RULE_01]
        end
    end
endmodule // mep_l1_par

module mep_crc_unit (
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    input  wire mep_pkg::mep_crc_in_t in_in,
    input  wire logic                 cmp_mode_in,
    input  wire logic [31:0]          expected_in,
    output logic [31:0]               crc_out,
    output logic                      mism_out
);
    logic        first_r;
    logic [31:0] base;
    logic [31:0] crc_nxt;

    function automatic logic [31:0] crc_word(input logic [31:0] c,
                                             input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ mep_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_comb begin
        base    = (in_in.start || first_r) ? mep_pkg::CRC_SEED : crc_out;
        crc_nxt = crc_word(base, in_in.data); // [RULE_09]
    end

    // after a last word the next word reseeds, so scrub passes repeat
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            crc_out <= mep_pkg::CRC_SEED;
            first_r <= 1'b1;
        end else if (in_in.valid) begin
            crc_out <= crc_nxt; // [RULE_09]
            first_r <= in_in.last; // [RULE_10]
        end else if (in_in.start) begin
            crc_out <= mep_pkg::CRC_SEED;
            first_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mism_out <= 1'b0;
        end else begin
            mism_out <= in_in.valid && in_in.last && cmp_mode_in &&
                        (crc_nxt != expected_in); // [RULE_13]
        end
    end
endmodule // mep_crc_unit

module mep_top (
    input  wire logic                         sys_clk_in,
    input  wire logic                         rst_in,
    input  wire logic [mep_pkg::REG_AW-1:0]   reg_addr_in,
    input  wire logic [31:0]                  reg_wdata_in,
    input  wire logic                         reg_we_in,
    input  wire logic                         reg_re_in,
    output logic [31:0]                       reg_rdata_out,
    input  wire mep_pkg::mep_l1_acc_t         l1i_acc_in,
    output logic [3:0]                        l1i_wpar_out,
    output logic                              l1i_err_event_out,
    input  wire mep_pkg::mep_l1_acc_t         l1d_acc_in,
    output logic [3:0]                        l1d_wpar_out,
    output logic                              l1d_err_event_out,
    input  wire mep_pkg::mep_l2_req_t         l2_req_in,
    output logic                              l2_busy_out,
    output logic [31:0]                       l2_rdata_out,
    output logic                              l2_rvalid_out,
    output logic [mep_pkg::L2_AW-1:0]         l2m_addr_out,
    output logic                              l2m_we_out,
    output logic                              l2m_re_out,
    output logic [mep_pkg::CW-1:0]            l2m_wdata_out,
    input  wire logic [mep_pkg::CW-1:0]       l2m_rdata_in,
    output logic                              ded_event_out,
    input  wire mep_pkg::mep_crc_in_t         dma0_crc_in,
    input  wire mep_pkg::mep_crc_in_t         dma1_crc_in,
    input  wire logic                         boot_active_in,
    input  wire mep_pkg::mep_crc_in_t         boot_crc_in,
    output logic [1:0]                        crc_event_out,
    output logic                              irq_out
);
    typedef enum logic [1:0] {L2_IDLE, L2_ISSUE, L2_DATA} mep_l2_st_t;

    mep_l2_st_t            st_r;
    mep_pkg::mep_l2_req_t  req_r;
    mep_pkg::mep_dec_t     dec;
    mep_pkg::mep_crc_in_t  crc0_src;
    logic [31:0]           merged;
    logic                  bank_en;
    logic                  sec_r;
    logic                  ded_r;
    logic [31:0]           ctrl_r;
    logic [31:0]           mask_r;
    logic [31:0]           exp0_r;
    logic [31:0]           exp1_r;
    logic [mep_pkg::NSTAT-1:0] stat_r;
    logic [mep_pkg::NSTAT-1:0] stat_nxt;
    logic [mep_pkg::NSTAT-1:0] ev;
    logic [31:0]           crc0_val;
    logic [31:0]           crc1_val;

    function automatic logic [38:0] ecc_enc(input logic [31:0] d);
        logic [38:0] cw;
        int          j;
        cw = '0;
        j  = 0;
        for (int i = 1; i < 39; i++) begin
            if ((i & (i - 1)) != 0) begin
                cw[i] = d[j];
                j++;
            end
        end
        for (int p = 0; p < 6; p++) begin
            for (int i = 1; i < 39; i++) begin
                if (i[p] && (i != (1 << p))) begin
                    cw[1 << p] = cw[1 << p] ^ cw[i];
                end
            end
        end
        cw[0] = ^cw[38:1];
        return cw;
    endfunction

    function automatic mep_pkg::mep_dec_t ecc_dec(input logic [38:0] cw_in,
                                                  input logic        fix);
        logic [38:0]       cw;
        logic [5:0]        syn;
        logic              ovr;
        int                j;
        mep_pkg::mep_dec_t r;
        cw  = cw_in;
        syn = '0;
        j   = 0;
        r   = '0;
        for (int p = 0; p < 6; p++) begin
            for (int i = 1; i < 39; i++) begin
                if (i[p]) begin
                    syn[p] = syn[p] ^ cw[i];
                end
            end
        end
        ovr = ^cw;
        // a disabled bank passes raw data and flags nothing
        if (fix) begin
            if (ovr && (syn < 6'd39)) begin
                r.sgl = 1'b1;
                cw[syn] = ~cw[syn];
            end else if (ovr || (syn != 6'd0)) begin
                r.dbl = 1'b1;
            end
        end
        for (int i = 1; i < 39; i++) begin
            if ((i & (i - 1)) != 0) begin
                r.data[j] = cw[i];
                j++;
            end
        end
        return r;
    endfunction

    mep_l1_par u_l1i (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .acc_in     (l1i_acc_in),
        .wpar_out   (l1i_wpar_out),
        .err_out    (l1i_err_event_out)
    ); // [RULE_02]

    mep_l1_par u_l1d (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .acc_in     (l1d_acc_in),
        .wpar_out   (l1d_wpar_out),
        .err_out    (l1d_err_event_out)
    ); // [RULE_02]

    always_comb begin
        bank_en = ctrl_r[mep_pkg::CTRL_ECC_EN_LSB +
                         int'(req_r.addr[mep_pkg::BANK_LSB +: 2])]; // [RULE_04]
        dec     = ecc_dec(l2m_rdata_in, bank_en); // [RULE_03]
        merged  = dec.data;
        for (int b = 0; b < 4; b++) begin
            if (req_r.be[b]) begin
                merged[8*b +: 8] = req_r.wdata[8*b +: 8]; // [RULE_07]
            end
        end
    end

    // partial writes cost one read first; full words go straight out
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_r          <= L2_IDLE;
            req_r         <= '0;
            l2_busy_out   <= 1'b0;
            l2m_addr_out  <= '0;
            l2m_we_out    <= 1'b0;
            l2m_re_out    <= 1'b0;
            l2m_wdata_out <= '0;
        end else begin
            l2m_we_out <= 1'b0;
            l2m_re_out <= 1'b0;
            case (st_r)
                L2_IDLE: begin
                    if (l2_req_in.valid) begin
                        req_r        <= l2_req_in;
                        l2m_addr_out <= l2_req_in.addr;
                        if (l2_req_in.we && l2_req_in.be == mep_pkg::BE_FULL) begin
                            l2m_we_out    <= 1'b1;
                            l2m_wdata_out <= ecc_enc(l2_req_in.wdata); // [RULE_03]
                        end else begin
                            l2m_re_out  <= 1'b1;
                            l2_busy_out <= 1'b1;
                            st_r        <= L2_ISSUE;
                        end
                    end
                end
                L2_ISSUE: begin
                    st_r <= L2_DATA;
                end
                L2_DATA: begin
                    if (req_r.we) begin
                        l2m_we_out    <= 1'b1;
                        l2m_wdata_out <= ecc_enc(merged); // [RULE_07]
                    end
                    l2_busy_out <= 1'b0;
                    st_r        <= L2_IDLE;
                end
                default: begin
                    st_r <= L2_IDLE;
                end
            endcase
        end
    end

    // corrected data goes back with no extra wait and no error marker
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            l2_rdata_out  <= '0;
            l2_rvalid_out <= 1'b0;
        end else begin
            l2_rvalid_out <= (st_r == L2_DATA) && !req_r.we; // [RULE_05]
            if ((st_r == L2_DATA) && !req_r.we) begin
                l2_rdata_out <= dec.data; // [RULE_05]
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sec_r         <= 1'b0;
            ded_r         <= 1'b0;
            ded_event_out <= 1'b0;
        end else begin
            sec_r         <= (st_r == L2_DATA) && dec.sgl;
            ded_r         <= (st_r == L2_DATA) && dec.dbl;
            ded_event_out <= (st_r == L2_DATA) && dec.dbl &&
                             ctrl_r[mep_pkg::CTRL_DED_REP]; // [RULE_06]
        end
    end

    // boot loads borrow unit 0; dma0 is ignored while boot runs
    always_comb begin
        crc0_src = boot_active_in ? boot_crc_in : dma0_crc_in; // [RULE_11]
    end

    mep_crc_unit u_crc0 (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .in_in       (crc0_src),
        .cmp_mode_in (ctrl_r[mep_pkg::CTRL_CRC0_CMP]),
        .expected_in (exp0_r),
        .crc_out     (crc0_val),
        .mism_out    (crc_event_out[0])
    ); // [RULE_08]

    mep_crc_unit u_crc1 (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .in_in       (dma1_crc_in),
        .cmp_mode_in (ctrl_r[mep_pkg::CTRL_CRC1_CMP]),
        .expected_in (exp1_r),
        .crc_out     (crc1_val),
        .mism_out    (crc_event_out[1])
    ); // [RULE_08]

    always_comb begin
        ev = '0;
        ev[mep_pkg::ST_L1I]  = l1i_err_event_out; // [RULE_12]
        ev[mep_pkg::ST_L1D]  = l1d_err_event_out; // [RULE_12]
        ev[mep_pkg::ST_SEC]  = sec_r;
        ev[mep_pkg::ST_DED]  = ded_r;
        ev[mep_pkg::ST_CRC0] = crc_event_out[0]; // [RULE_13]
        ev[mep_pkg::ST_CRC1] = crc_event_out[1]; // [RULE_13]
        stat_nxt = stat_r;
        if (reg_re_in && reg_addr_in == mep_pkg::REG_STAT) begin
            stat_nxt = '0;
        end
        stat_nxt = stat_nxt | ev; // set wins over read-clear
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            stat_r  <= '0;
            irq_out <= 1'b0;
        end else begin
            stat_r  <= stat_nxt;
            irq_out <= |(stat_nxt & mask_r[mep_pkg::NSTAT-1:0]);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl_r <= mep_pkg::CTRL_RST; // [RULE_04]
            mask_r <= mep_pkg::MASK_RST;
            exp0_r <= mep_pkg::EXP_RST;
            exp1_r <= mep_pkg::EXP_RST;
        end else if (reg_we_in) begin
            case (reg_addr_in)
                mep_pkg::REG_CTRL:    ctrl_r <= reg_wdata_in; // [RULE_04]
                mep_pkg::REG_MASK:    mask_r <= reg_wdata_in;
                mep_pkg::REG_CRC0EXP: exp0_r <= reg_wdata_in;
                mep_pkg::REG_CRC1EXP: exp1_r <= reg_wdata_in;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_re_in) begin
            case (reg_addr_in)
                mep_pkg::REG_CTRL:    reg_rdata_out <= ctrl_r;
                mep_pkg::REG_STAT:    reg_rdata_out <= {26'h0, stat_r};
                mep_pkg::REG_MASK:    reg_rdata_out <= mask_r;
                mep_pkg::REG_CRC0RES: reg_rdata_out <= crc0_val;
                mep_pkg::REG_CRC1RES: reg_rdata_out <= crc1_val;
                mep_pkg::REG_CRC0EXP: reg_rdata_out <= exp0_r;
                mep_pkg::REG_CRC1EXP: reg_rdata_out <= exp1_r;
                default:              reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end
endmodule // mep_top

// ### verification/memory_error_protection_test.sv
/*
 * memory_error_protection_test: directed bench for mep_top.
 * Assumes the L2 array model mep_l2_mem and a 50 ns system clock.
 */
module memory_error_protection_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 0, rst_in = 1, reg_we_in = 0, reg_re_in = 0;
    logic boot_active_in = 0, l2_busy_out, l2_rvalid_out, l2m_we_out;
    logic l2m_re_out, ded_event_out, irq_out, l1i_err_event_out;
    logic l1d_err_event_out;
    logic [3:0] reg_addr_in = 0, l1i_wpar_out, l1d_wpar_out, p;
    logic [31:0] reg_wdata_in = 0, reg_rdata_out, l2_rdata_out, w, q, x;
    logic [1:0] crc_event_out, csel = 0, ev;
    logic [mep_pkg::L2_AW-1:0] l2m_addr_out;
    logic [mep_pkg::CW-1:0] l2m_wdata_out, l2m_rdata_in, flip = '0;
    mep_pkg::mep_l1_acc_t l1i_acc_in = '0, l1d_acc_in = '0;
    mep_pkg::mep_l2_req_t l2_req_in = '0;
    mep_pkg::mep_crc_in_t cd = '0, dma0_crc_in, dma1_crc_in, boot_crc_in;
    int bad_count = 0, n_tests = 0, cyc = 0, ded_n = 0;
    logic [3:0] ra [7] = '{mep_pkg::REG_CTRL, mep_pkg::REG_MASK,
        mep_pkg::REG_STAT, mep_pkg::REG_CRC0RES, mep_pkg::REG_CRC1RES,
        mep_pkg::REG_CRC0EXP, 4'hF};
    logic [31:0] rv [7] = '{mep_pkg::CTRL_RST, mep_pkg::MASK_RST, 32'h0,
        mep_pkg::CRC_SEED, mep_pkg::CRC_SEED, mep_pkg::EXP_RST, 32'h0};

    assign dma0_crc_in = (csel == 2'd0) ? cd : '0;
    assign dma1_crc_in = (csel == 2'd1) ? cd : '0;
    assign boot_crc_in = (csel == 2'd2) ? cd : '0;

    mep_top DUT (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
        .reg_we_in, .reg_re_in, .reg_rdata_out, .l1i_acc_in, .l1i_wpar_out,
        .l1i_err_event_out, .l1d_acc_in, .l1d_wpar_out, .l1d_err_event_out,
        .l2_req_in, .l2_busy_out, .l2_rdata_out, .l2_rvalid_out,
        .l2m_addr_out, .l2m_we_out, .l2m_re_out, .l2m_wdata_out,
        .l2m_rdata_in, .ded_event_out, .dma0_crc_in, .dma1_crc_in,
        .boot_active_in, .boot_crc_in, .crc_event_out, .irq_out);
    mep_l2_mem u_mem (.sys_clk_in, .addr_in(l2m_addr_out),
        .we_in(l2m_we_out), .re_in(l2m_re_out), .wdata_in(l2m_wdata_out),
        .flip_in(flip), .rdata_out(l2m_rdata_in));

    initial forever #25 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cyc++;
        if (ded_event_out === 1'b1)
            ded_n++;
        // the whole sequence needs well under 1500 cycles
        if (cyc == 4000) begin
            bad_count++;
            stop_test();
        end
    end

    task chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_we_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_we_in <= 1'b0;
    endtask
    task rchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_re_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_re_in <= 1'b0;
        #1 chk(reg_rdata_out, e);
    endtask
    // fixed walk: request c0, result c3; rvalid must not slip
    task l2(input logic w1, input logic [3:0] be, input logic [13:0] a,
            input logic [31:0] d);
        @(posedge sys_clk_in);
        l2_req_in <= {1'b1, w1, be, a, d};
        @(posedge sys_clk_in);
        l2_req_in.valid <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1 q = l2_rdata_out;
        if (!w1)
            chk(l2_rvalid_out, 1);
    endtask
    task l1(input logic d, input mep_pkg::mep_l1_acc_t a);
        @(posedge sys_clk_in);
        if (d)
            l1d_acc_in <= a;
        else
            l1i_acc_in <= a;
        @(posedge sys_clk_in);
        l1i_acc_in <= '0;
        l1d_acc_in <= '0;
        #1;
    endtask
    function automatic logic [31:0] cstep(input logic [31:0] c, d);
        for (int i = 31; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? mep_pkg::CRC_POLY : 32'h0);
        return c;
    endfunction
    task frame(input logic [1:0] s, input logic st);
        x = mep_pkg::CRC_SEED;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_in);
            csel <= s;
            cd <= {st && i == 0, 1'b1, i == 3, 32'h13579BDF + 32'(i) + 32'(s)};
            x = cstep(x, 32'h13579BDF + 32'(i) + 32'(s));
        end
        @(posedge sys_clk_in);
        cd <= '0;
        #1 ev = crc_event_out;
    endtask
    task stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        foreach (ra[i])
            rchk(ra[i], rv[i]);
        wr(mep_pkg::REG_STAT, 32'h3F);
        wr(4'hF, 32'h1);
        rchk(mep_pkg::REG_STAT, 32'h0);
        wr(mep_pkg::REG_MASK, 32'h4);
        l2(1, 4'hF, 14'h0010, 32'hA5C31E77);
        l2(0, 4'hF, 14'h0010, 32'h0);
        chk(q, 32'hA5C31E77);
        flip = 39'h80;
        l2(0, 4'hF, 14'h0010, 32'h0);
        chk(q, 32'hA5C31E77);
        repeat (2) @(posedge sys_clk_in);
        #1 chk(irq_out, 1);
        rchk(mep_pkg::REG_STAT, 32'h4);
        @(posedge sys_clk_in);
        #1 chk(irq_out, 0);
        // report disabled: status still records the double error
        flip = 39'h100020;
        l2(0, 4'hF, 14'h0010, 32'h0);
        repeat (2) @(posedge sys_clk_in);
        #1 chk(ded_n, 0);
        chk(irq_out, 0);
        rchk(mep_pkg::REG_STAT, 32'h8);
        wr(mep_pkg::REG_CTRL, 32'h1F);
        l2(0, 4'hF, 14'h0010, 32'h0);
        repeat (2) @(posedge sys_clk_in);
        chk(ded_n, 1);
        rchk(mep_pkg::REG_STAT, 32'h8);
        flip = '0;
        l2(1, 4'h2, 14'h0010, 32'h0000BB00);
        l2(1, 4'hC, 14'h0010, 32'h12340000);
        flip = 39'h40000000;
        l2(0, 4'hF, 14'h0010, 32'h0);
        chk(q, 32'h1234BB77);
        rchk(mep_pkg::REG_STAT, 32'h4);
        wr(mep_pkg::REG_CTRL, 32'h1E);
        flip = 39'h8;
        l2(0, 4'hF, 14'h0010, 32'h0);
        chk(q, 32'h1234BB76);
        rchk(mep_pkg::REG_STAT, 32'h0);
        flip = '0;
        for (int d = 0; d < 2; d++) begin
            w = d ? 32'hFF00FE01 : 32'h01030700;
            p = d ? 4'h3 : 4'hA;
            l1(d[0], {1'b1, w, 1'b0, 32'h0, 4'h0});
            chk(d ? l1d_wpar_out : l1i_wpar_out, p);
            l1(d[0], {1'b0, 32'h0, 1'b1, w, p});
            chk(d ? l1d_err_event_out : l1i_err_event_out, 0);
            l1(d[0], {1'b0, 32'h0, 1'b1, w, p ^ 4'h4});
            chk(d ? l1d_err_event_out : l1i_err_event_out, 1);
        end
        rchk(mep_pkg::REG_STAT, 32'h3);
        frame(2'd1, 1'b1);
        chk(ev, 2'b00);
        rchk(mep_pkg::REG_CRC1RES, x);
        frame(2'd1, 1'b0);
        rchk(mep_pkg::REG_CRC1RES, x);
        wr(mep_pkg::REG_CTRL, 32'h10F);
        wr(mep_pkg::REG_CRC0EXP, x ^ 32'h1);
        frame(2'd0, 1'b1);
        chk(ev, 2'b01);
        rchk(mep_pkg::REG_STAT, 32'h10);
        // boot stream while boot is off: unit 0 stays still, x gets boot sum
        frame(2'd2, 1'b1);
        wr(mep_pkg::REG_CRC0EXP, x);
        boot_active_in <= 1'b1;
        frame(2'd2, 1'b1);
        chk(ev, 2'b00);
        rchk(mep_pkg::REG_CRC0RES, x);
        stop_test();
    end
endmodule // memory_error_protection_test

// ### verification/mep_l2_mem.sv
/*
 * mep_l2_mem: behavioural L2 array that stores 39-bit codewords.
 * Assumes read data is due the cycle after the read strobe; a flip mask
 * from the bench corrupts what is read, to inject upsets.
 */
module mep_l2_mem (
    input  wire logic                     sys_clk_in,
    input  wire logic [mep_pkg::L2_AW-1:0] addr_in,
    input  wire logic                     we_in,
    input  wire logic                     re_in,
    input  wire logic [mep_pkg::CW-1:0]    wdata_in,
    input  wire logic [mep_pkg::CW-1:0]    flip_in,
    output logic      [mep_pkg::CW-1:0]    rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [mep_pkg::CW-1:0] mem [int];

    initial rdata_out = '0;
    always @(posedge sys_clk_in) begin
        if (we_in)
            mem[addr_in] = wdata_in;
        // data hold ends after one cycle: then the word inverts each cycle, so stale data returns every second cycle
        if (re_in)
            rdata_out <= (mem.exists(addr_in) ? mem[addr_in] : '0) ^ flip_in;
        else
            rdata_out <= ~rdata_out;
    end
endmodule // mep_l2_mem

// ### verification/mep_top_checker.sv
/*
 * mep_top_checker: port-level assertions for mep_top.
 * Assumes one clock domain and the synchronous reset rst_in.
 */
module mep_top_checker (
    input wire logic                    sys_clk_in,
    input wire logic                    rst_in,
    input wire logic                    reg_re_in,
    input wire logic [31:0]             reg_rdata_out,
    input wire mep_pkg::mep_l1_acc_t     l1i_acc_in,
    input wire logic [3:0]              l1i_wpar_out,
    input wire logic                    l1i_err_event_out,
    input wire mep_pkg::mep_l1_acc_t     l1d_acc_in,
    input wire logic                    l1d_err_event_out,
    input wire mep_pkg::mep_l2_req_t     l2_req_in,
    input wire logic                    l2_busy_out,
    input wire logic                    l2_rvalid_out,
    input wire logic                    l2m_re_out,
    input wire logic                    l2m_we_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    function automatic logic [3:0] bpar(input logic [31:0] d);
        for (int b = 0; b < 4; b++)
            bpar[b] = ^d[8*b+:8];
    endfunction

    sequence rd_path;
        l2m_re_out ##2 l2_rvalid_out;
    endsequence
    sequence rmw_path;
        l2m_re_out ##2 l2m_we_out;
    endsequence

    wpar_calc_a: assert property (l1i_acc_in.wr |=>
        l1i_wpar_out == bpar($past(l1i_acc_in.wdata))) else $error("wpar");
    ipar_err_a: assert property (l1i_acc_in.rd_valid &&
        l1i_acc_in.rpar != bpar(l1i_acc_in.rdata) |=> l1i_err_event_out)
        else $error("l1i err missing");
    ipar_quiet_a: assert property (!l1i_acc_in.rd_valid |=>
        !l1i_err_event_out) else $error("l1i err spurious");
    dpar_err_a: assert property (l1d_acc_in.rd_valid &&
        l1d_acc_in.rpar != bpar(l1d_acc_in.rdata) |=> l1d_err_event_out)
        else $error("l1d err missing");
    l2_read_a: assert property (l2_req_in.valid && !l2_req_in.we &&
        !l2_busy_out |=> rd_path) else $error("read timing");
    l2_merge_a: assert property (l2_req_in.valid && l2_req_in.we &&
        l2_req_in.be != mep_pkg::BE_FULL && !l2_busy_out |=> rmw_path)
        else $error("merge timing");
    l2_full_a: assert property (l2_req_in.valid && l2_req_in.we &&
        l2_req_in.be == mep_pkg::BE_FULL && !l2_busy_out |=>
        l2m_we_out && !l2m_re_out) else $error("full write");
    busy_span_a: assert property (l2m_re_out |->
        l2_busy_out ##1 l2_busy_out ##1 !l2_busy_out) else $error("busy");
    rdata_idle_a: assert property (!reg_re_in |=>
        reg_rdata_out == 32'h0) else $error("rdata not idle");
endmodule // mep_top_checker

bind mep_top mep_top_checker u_chk (.sys_clk_in, .rst_in, .reg_re_in,
    .reg_rdata_out, .l1i_acc_in, .l1i_wpar_out, .l1i_err_event_out,
    .l1d_acc_in, .l1d_err_event_out, .l2_req_in, .l2_busy_out,
    .l2_rvalid_out, .l2m_re_out, .l2m_we_out);
